// ==== pkg/tcpwm_pkg.sv ====
// Shared constants and types of the three-channel 8+4 pulse width modulator.
package tcpwm_pkg;

   localparam int NUM_CH = 3;
   localparam int DUTY_W = 12;
   localparam int COARSE_W = 8;
   localparam int FINE_W = 4;
   localparam int BASE_W = 8;
   localparam int SUB_W = 4;
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;

   // The slow prescale divides the system clock by four.
   localparam logic [1:0] PRESCALE_LAST = 2'h3;
   // One full cycle is 4096 channel clocks: sixteen sub-cycles of 256.
   localparam logic [11:0] CYCLE_LAST = 12'hFFF;

   // Byte addresses of the register map.
   localparam logic [7:0] OFF_DUTY_LOW_CH0 = 8'h00;
   localparam logic [7:0] OFF_DUTY_HIGH_CH0 = 8'h04;
   localparam logic [7:0] OFF_BASE_PERIOD_CH0 = 8'h08;
   localparam logic [7:0] CH_STRIDE = 8'h0C;
   localparam logic [7:0] OFF_CONTROL = 8'h24;
   localparam logic [7:0] OFF_PORT_DIR = 8'h28;
   localparam logic [7:0] OFF_PORT_DATA = 8'h2C;
   localparam logic [7:0] OFF_PULL_HIGH = 8'h30;
   localparam logic [7:0] OFF_STATUS = 8'h34;

   // Field positions.
   localparam int DL_ENABLE_BIT = 0;
   localparam int DL_FINE_LSB = 4;
   localparam int CTRL_PRESCALE_BIT = 0;
   localparam int STATUS_PIN_LSB = 0;
   localparam int STATUS_OUT_LSB = 3;
   localparam int STATUS_SUB_LSB = 8;

   // Values after reset that are not zero: every pin starts as an input.
   localparam logic [2:0] RST_PORT_DIR = 3'h7;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [3:0] {
      REG_DUTY_LOW,
      REG_DUTY_HIGH,
      REG_BASE_PERIOD,
      REG_CONTROL,
      REG_PORT_DIR,
      REG_PORT_DATA,
      REG_PULL_HIGH,
      REG_STATUS,
      REG_NONE
   } tcpwm_reg_kind_t;

   typedef struct packed {
      tcpwm_reg_kind_t kind;
      logic [1:0] chan;
   } tcpwm_reg_sel_t;

endpackage : tcpwm_pkg

// ==== core/tcpwm_chan.sv ====
// One 8+4 modulator channel: base-period divider, 12-bit cycle counter and compare.
module tcpwm_chan (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic enable_i,
   input wire logic [tcpwm_pkg::DUTY_W-1:0] duty_i,
   input wire logic [tcpwm_pkg::BASE_W-1:0] base_period_i,
   input wire logic pre_tick_i,
   output logic modulator_o,
   output logic [tcpwm_pkg::SUB_W-1:0] sub_cycle_o
);

   typedef struct packed {
      logic [tcpwm_pkg::BASE_W-1:0] base_cnt;
      logic [tcpwm_pkg::DUTY_W-1:0] cyc_cnt;
      logic [tcpwm_pkg::DUTY_W-1:0] shadow;
      logic out;
      logic run;
   } tcpwm_chan_state_t;

   tcpwm_chan_state_t s_r;
   tcpwm_chan_state_t s_nxt;

   // High while the phase is below coarse, plus one clock in the first fine sub-cycles.
   function automatic logic level(input logic [11:0] duty, input logic [11:0] cnt);
      logic [8:0] limit;
      limit = {1'b0, duty[11:4]};
      if (cnt[11:8] < duty[3:0]) begin
         limit = limit + 9'h001;
      end
      level = {1'b0, cnt[7:0]} < limit;
   endfunction : level

   always_comb begin
      s_nxt = s_r;
      if (!enable_i) begin
         // Idle channel tracks the duty value so the first cycle uses the latest write.
         s_nxt.base_cnt = '0;
         s_nxt.cyc_cnt = '0;
         s_nxt.shadow = duty_i;
         s_nxt.out = 1'b0;
         s_nxt.run = 1'b0;
      end else if (!s_r.run) begin
         // Enable and fine part share one register, so the first enabled clock loads the shadow afresh.
         // The counters hold at phase 0 here so that sub-cycle 0 gets its full 256 channel clocks.
         s_nxt.shadow = duty_i;
         s_nxt.run = 1'b1;
         s_nxt.out = level(duty_i, s_r.cyc_cnt);
      end else begin
         if (pre_tick_i) begin
            // Compare with >= so a smaller base period never strands the divider.
            if (s_r.base_cnt >= base_period_i) begin
               s_nxt.base_cnt = '0;
               s_nxt.cyc_cnt = s_r.cyc_cnt + 12'h001;
               if (s_r.cyc_cnt == tcpwm_pkg::CYCLE_LAST) begin
                  s_nxt.shadow = duty_i;
               end
            end else begin
               s_nxt.base_cnt = s_r.base_cnt + 8'h01;
            end
         end
         s_nxt.out = level(s_nxt.shadow, s_nxt.cyc_cnt);
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= '0;
      end else if (clk_en_i) begin
         s_r <= s_nxt;
      end
   end

   assign modulator_o = s_r.out;
   assign sub_cycle_o = s_r.cyc_cnt[11:8];

endmodule : tcpwm_chan

// ==== core/tcpwm_top.sv ====
// Top of the three-channel 8+4 modulator: AXI4-Lite registers, prescaler and pin sharing.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.

// Functional notes
// - Three independent modulator channels, each with its own programmable duty.
// - Each channel holds a 12-bit duty value split over a low and high register.
// - Channel clock is system clock or system clock/4, divided by base period plus one.
// - One full output cycle spans 4096 channel clocks; duty is value/4096.
// - The full cycle holds sixteen sub-cycles of 256 channel clocks each.
// - Duty bits 11..4 are the coarse part, bits 3..0 the fine part.
// - Sub-cycle i is high coarse+1 clocks when i is below fine, else coarse.
// - Hardware splits the cycle; software writes only the 12-bit duty value.
// - Channel 0 drives pin A4, channel 1 pin A5, channel 2 pin B0.
// - Bit 0 of the low duty register enables the channel onto its pin.
// - Enabled output pin: data bit 1 passes the waveform, data bit 0 forces low.
// - Enabled channel with pin set as input behaves as input; pull-high only when its pull-high bit is set.
// - Each channel has an 8-bit read/write base-period register.
module tcpwm_top (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic [tcpwm_pkg::AXI_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [tcpwm_pkg::AXI_DATA_W-1:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic [tcpwm_pkg::AXI_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [tcpwm_pkg::AXI_DATA_W-1:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [tcpwm_pkg::NUM_CH-1:0] pin_i,
   output logic [tcpwm_pkg::NUM_CH-1:0] pin_o,
   output logic [tcpwm_pkg::NUM_CH-1:0] pin_oe_n_o,
   output logic [tcpwm_pkg::NUM_CH-1:0] pin_pull_high_o
);

   typedef struct packed {
      // Write channel holding registers.
      logic aw_full;
      logic [tcpwm_pkg::AXI_ADDR_W-1:0] aw_addr;
      logic w_full;
      logic [7:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      // Read channel.
      logic arready;
      logic rvalid;
      logic [tcpwm_pkg::AXI_DATA_W-1:0] rdata;
      logic [1:0] rresp;
      // Channel registers.
      logic [tcpwm_pkg::NUM_CH-1:0][tcpwm_pkg::FINE_W-1:0] fine;
      logic [tcpwm_pkg::NUM_CH-1:0] enable;
      logic [tcpwm_pkg::NUM_CH-1:0][tcpwm_pkg::COARSE_W-1:0] coarse;
      logic [tcpwm_pkg::NUM_CH-1:0][tcpwm_pkg::BASE_W-1:0] base;
      logic prescale_sel;
      logic [1:0] prescale_cnt;
      // Shared port control, one bit per channel pin.
      logic [tcpwm_pkg::NUM_CH-1:0] port_dir;
      logic [tcpwm_pkg::NUM_CH-1:0] port_data;
      logic [tcpwm_pkg::NUM_CH-1:0] pull_high;
      logic [tcpwm_pkg::NUM_CH-1:0] pin_meta;
      logic [tcpwm_pkg::NUM_CH-1:0] pin_sync;
      // Pin drivers.
      logic [tcpwm_pkg::NUM_CH-1:0] pin_out;
      logic [tcpwm_pkg::NUM_CH-1:0] pin_oe_n;
      logic [tcpwm_pkg::NUM_CH-1:0] pin_pull;
   } tcpwm_top_state_t;

   localparam tcpwm_top_state_t ST_RESET = '{
      port_dir: tcpwm_pkg::RST_PORT_DIR,
      pin_oe_n: tcpwm_pkg::RST_PORT_DIR,
      default: '0
   };

   tcpwm_top_state_t s_r;
   tcpwm_top_state_t s_nxt;

   logic pre_tick;
   logic [tcpwm_pkg::NUM_CH-1:0] mod_out;
   logic [tcpwm_pkg::NUM_CH-1:0][tcpwm_pkg::SUB_W-1:0] sub_cycle;

   // Maps a byte address onto a register kind and channel; low address bits are ignored.
   function automatic tcpwm_pkg::tcpwm_reg_sel_t reg_select(input logic [tcpwm_pkg::AXI_ADDR_W-1:0] addr);
      tcpwm_pkg::tcpwm_reg_sel_t sel;
      logic [7:0] word;
      sel.kind = tcpwm_pkg::REG_NONE;
      sel.chan = 2'h0;
      word = {addr[7:2], 2'h0};
      for (int c = 0; c < tcpwm_pkg::NUM_CH; c++) begin
         if (word == 8'(tcpwm_pkg::OFF_DUTY_LOW_CH0 + c * tcpwm_pkg::CH_STRIDE)) begin
            sel.kind = tcpwm_pkg::REG_DUTY_LOW;
            sel.chan = 2'(c);
         end
         if (word == 8'(tcpwm_pkg::OFF_DUTY_HIGH_CH0 + c * tcpwm_pkg::CH_STRIDE)) begin
            sel.kind = tcpwm_pkg::REG_DUTY_HIGH;
            sel.chan = 2'(c);
         end
         if (word == 8'(tcpwm_pkg::OFF_BASE_PERIOD_CH0 + c * tcpwm_pkg::CH_STRIDE)) begin
            sel.kind = tcpwm_pkg::REG_BASE_PERIOD;
            sel.chan = 2'(c);
         end
      end
      case (word)
         tcpwm_pkg::OFF_CONTROL: begin
            sel.kind = tcpwm_pkg::REG_CONTROL;
         end
         tcpwm_pkg::OFF_PORT_DIR: begin
            sel.kind = tcpwm_pkg::REG_PORT_DIR;
         end
         tcpwm_pkg::OFF_PORT_DATA: begin
            sel.kind = tcpwm_pkg::REG_PORT_DATA;
         end
         tcpwm_pkg::OFF_PULL_HIGH: begin
            sel.kind = tcpwm_pkg::REG_PULL_HIGH;
         end
         tcpwm_pkg::OFF_STATUS: begin
            sel.kind = tcpwm_pkg::REG_STATUS;
         end
         default: begin
         end
      endcase
      return sel;
   endfunction : reg_select

   // The prescaler is shared, so all channels with the same setting step in phase.
   assign pre_tick = s_r.prescale_sel ? (s_r.prescale_cnt == tcpwm_pkg::PRESCALE_LAST) : 1'b1;

   for (genvar g = 0; g < tcpwm_pkg::NUM_CH; g++) begin : g_chan
      tcpwm_chan u_chan (
         .core_clk_i(core_clk_i),
         .resetn_i(resetn_i),
         .clk_en_i(clk_en_i),
         .enable_i(s_r.enable[g]),
         .duty_i({s_r.coarse[g], s_r.fine[g]}),
         .base_period_i(s_r.base[g]),
         .pre_tick_i(pre_tick),
         .modulator_o(mod_out[g]),
         .sub_cycle_o(sub_cycle[g])
      );
   end

   always_comb begin
      tcpwm_pkg::tcpwm_reg_sel_t wsel;
      tcpwm_pkg::tcpwm_reg_sel_t rsel;
      logic [tcpwm_pkg::AXI_DATA_W-1:0] rd;
      wsel = reg_select(s_r.aw_addr);
      rsel = reg_select(s_axi_araddr_i);
      rd = 32'h0000_0000;
      s_nxt = s_r;

      s_nxt.prescale_cnt = s_r.prescale_cnt + 2'h1;

      // Address and data are taken independently, in either order.
      if (s_axi_awvalid_i && s_r.awready) begin
         s_nxt.aw_full = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_r.wready) begin
         s_nxt.w_full = 1'b1;
         s_nxt.w_data = s_axi_wdata_i[7:0];
         s_nxt.w_lane0 = s_axi_wstrb_i[0];
      end
      if (s_r.bvalid && s_axi_bready_i) begin
         s_nxt.bvalid = 1'b0;
      end

      // Every writable register fits in eight bits, so only byte lane 0 carries a write.
      if (s_r.aw_full && s_r.w_full && !s_r.bvalid) begin
         s_nxt.aw_full = 1'b0;
         s_nxt.w_full = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = tcpwm_pkg::RESP_OKAY;
         case (wsel.kind)
            tcpwm_pkg::REG_DUTY_LOW: begin
               if (s_r.w_lane0) begin
                  s_nxt.fine[wsel.chan] = s_r.w_data[tcpwm_pkg::DL_FINE_LSB +: tcpwm_pkg::FINE_W];
                  s_nxt.enable[wsel.chan] = s_r.w_data[tcpwm_pkg::DL_ENABLE_BIT];
               end
            end
            tcpwm_pkg::REG_DUTY_HIGH: begin
               if (s_r.w_lane0) begin
                  s_nxt.coarse[wsel.chan] = s_r.w_data;
               end
            end
            tcpwm_pkg::REG_BASE_PERIOD: begin
               if (s_r.w_lane0) begin
                  s_nxt.base[wsel.chan] = s_r.w_data;
               end
            end
            tcpwm_pkg::REG_CONTROL: begin
               if (s_r.w_lane0) begin
                  s_nxt.prescale_sel = s_r.w_data[tcpwm_pkg::CTRL_PRESCALE_BIT];
               end
            end
            tcpwm_pkg::REG_PORT_DIR: begin
               if (s_r.w_lane0) begin
                  s_nxt.port_dir = s_r.w_data[tcpwm_pkg::NUM_CH-1:0];
               end
            end
            tcpwm_pkg::REG_PORT_DATA: begin
               if (s_r.w_lane0) begin
                  s_nxt.port_data = s_r.w_data[tcpwm_pkg::NUM_CH-1:0];
               end
            end
            tcpwm_pkg::REG_PULL_HIGH: begin
               if (s_r.w_lane0) begin
                  s_nxt.pull_high = s_r.w_data[tcpwm_pkg::NUM_CH-1:0];
               end
            end
            tcpwm_pkg::REG_STATUS: begin
               // Read-only; the write is accepted and dropped.
            end
            default: begin
               s_nxt.bresp = tcpwm_pkg::RESP_SLVERR;
            end
         endcase
      end

      // A response outstanding blocks further requests until it is taken.
      s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
      s_nxt.wready = !s_nxt.w_full && !s_nxt.bvalid;

      case (rsel.kind)
         tcpwm_pkg::REG_DUTY_LOW: begin
            rd[tcpwm_pkg::DL_FINE_LSB +: tcpwm_pkg::FINE_W] = s_r.fine[rsel.chan];
            rd[tcpwm_pkg::DL_ENABLE_BIT] = s_r.enable[rsel.chan];
         end
         tcpwm_pkg::REG_DUTY_HIGH: begin
            rd[7:0] = s_r.coarse[rsel.chan];
         end
         tcpwm_pkg::REG_BASE_PERIOD: begin
            rd[7:0] = s_r.base[rsel.chan];
         end
         tcpwm_pkg::REG_CONTROL: begin
            rd[tcpwm_pkg::CTRL_PRESCALE_BIT] = s_r.prescale_sel;
         end
         tcpwm_pkg::REG_PORT_DIR: begin
            rd[tcpwm_pkg::NUM_CH-1:0] = s_r.port_dir;
         end
         tcpwm_pkg::REG_PORT_DATA: begin
            rd[tcpwm_pkg::NUM_CH-1:0] = s_r.port_data;
         end
         tcpwm_pkg::REG_PULL_HIGH: begin
            rd[tcpwm_pkg::NUM_CH-1:0] = s_r.pull_high;
         end
         tcpwm_pkg::REG_STATUS: begin
            rd[tcpwm_pkg::STATUS_PIN_LSB +: tcpwm_pkg::NUM_CH] = s_r.pin_sync;
            rd[tcpwm_pkg::STATUS_OUT_LSB +: tcpwm_pkg::NUM_CH] = mod_out;
            rd[tcpwm_pkg::STATUS_SUB_LSB +: tcpwm_pkg::NUM_CH * tcpwm_pkg::SUB_W] = sub_cycle;
         end
         default: begin
         end
      endcase

      if (s_r.rvalid && s_axi_rready_i) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rd;
         s_nxt.rresp = (rsel.kind == tcpwm_pkg::REG_NONE) ? tcpwm_pkg::RESP_SLVERR : tcpwm_pkg::RESP_OKAY;
      end
      s_nxt.arready = !s_nxt.rvalid;

      // Pins come from another domain, so two flops sit before the status read.
      s_nxt.pin_meta = pin_i;
      s_nxt.pin_sync = s_r.pin_meta;

      // Pin sharing: a disabled channel leaves the pin as a plain port bit.
      for (int c = 0; c < tcpwm_pkg::NUM_CH; c++) begin
         s_nxt.pin_oe_n[c] = s_r.port_dir[c];
         s_nxt.pin_pull[c] = s_r.pull_high[c] && s_r.port_dir[c];
         if (s_r.enable[c]) begin
            s_nxt.pin_out[c] = s_r.port_data[c] && mod_out[c];
         end else begin
            s_nxt.pin_out[c] = s_r.port_data[c];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_r <= ST_RESET;
      end else if (clk_en_i) begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready_o = s_r.awready;
   assign s_axi_wready_o = s_r.wready;
   assign s_axi_bresp_o = s_r.bresp;
   assign s_axi_bvalid_o = s_r.bvalid;
   assign s_axi_arready_o = s_r.arready;
   assign s_axi_rdata_o = s_r.rdata;
   assign s_axi_rresp_o = s_r.rresp;
   assign s_axi_rvalid_o = s_r.rvalid;
   assign pin_o = s_r.pin_out;
   assign pin_oe_n_o = s_r.pin_oe_n;
   assign pin_pull_high_o = s_r.pin_pull;

endmodule : tcpwm_top

// ==== tb/tcpwm_properties.sv ====
// Bus handshake and pin checks on the ports of the modulator top.
module tcpwm_properties (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic clk_en_i,
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   input wire logic [2:0] pin_o,
   input wire logic [2:0] pin_oe_n_o,
   input wire logic [2:0] pin_pull_high_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);
   aw_drop_a: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
      else $error("awready held after address taken");
   b_answer_a: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
      |-> ##[1:2] s_axi_bvalid_o) else $error("write response missing");
   b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("bvalid dropped without bready");
   r_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read data late");
   r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
      else $error("read data not held");
   ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
      else $error("arready high during read answer");
   pull_input_a: assert property ((pin_pull_high_o & ~pin_oe_n_o) == 3'h0)
      else $error("pull-high on a driven pin");
   en_freeze_a: assert property (!clk_en_i |=> $stable(pin_o) && $stable(pin_oe_n_o))
      else $error("pins moved while clock enable low");
   rst_state_a: assert property ($rose(resetn_i) |-> pin_oe_n_o == 3'h7 && !s_axi_bvalid_o)
      else $error("pins not inputs after reset");
   wr_seen_c: cover property (s_axi_bvalid_o && s_axi_bready_i);
   rd_seen_c: cover property (s_axi_rvalid_o && s_axi_rready_i);
   pwm_edge_c: cover property ($rose(pin_o[0]) && !pin_oe_n_o[0]);
endmodule : tcpwm_properties

bind tcpwm_top tcpwm_properties u_props (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
   .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i), .pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o),
   .pin_pull_high_o(pin_pull_high_o));

// ==== tb/tcpwm_load.sv ====
// Load on the three shared pins: follows a driven pin, else pull-high or a floating level.
module tcpwm_load (
   input wire logic core_clk_i,
   input wire logic [2:0] pin_o,
   input wire logic [2:0] pin_oe_n_o,
   input wire logic [2:0] pin_pull_high_o,
   output logic [2:0] pin_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic flt_r = 1'b0;
   always @(posedge core_clk_i) begin
      flt_r <= ~flt_r;
   end
   // A floating pin toggles so that a stale level can never pass for a real one.
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_i[i] = !pin_oe_n_o[i] ? pin_o[i] : (pin_pull_high_o[i] | flt_r);
      end
   end
endmodule : tcpwm_load

// ==== tb/tb_top.sv ====
// Self-checking bench of the three-channel modulator with a register model.
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic clk_en_i = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic awr, wr_rdy, bvalid, arr, rvalid;
   logic [1:0] bresp, rresp;
   logic [2:0] pin_i, pin_o, oe_n, pull;
   logic [15:0] rnd = 16'hAED5;
   int err_count = 0, total_checks = 0, cycles = 0;
   int mreg[int];

   tcpwm_top DUT (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .clk_en_i(clk_en_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata),
      .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_rdy), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pin_pull_high_o(pull));
   tcpwm_load u_load (.core_clk_i(core_clk_i), .pin_o(pin_o), .pin_oe_n_o(oe_n), .pin_pull_high_o(pull),
      .pin_i(pin_i));

   always #5 core_clk_i = ~core_clk_i;

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_of_test

   // The longest path is the prescaled modulator pass, well under this ceiling.
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 90000) begin
         err_count++;
         end_of_test();
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr

   // Writable bits of each mapped word; -1 marks the read-only status word or an unmapped address.
   function automatic int mask_of(input int a);
      if (a < 36) return (a % 12 == 0) ? 'hF1 : 'hFF;
      if (a == 36) return 1;
      if (a >= 40 && a <= 48) return 7;
      return -1;
   endfunction : mask_of

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask : cmp

   task automatic bus_wr(input int a, input int d);
      bit ah, wh;
      logic [1:0] r;
      int m;
      m = mask_of(a);
      @(posedge core_clk_i);
      awaddr <= a[7:0];
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(negedge core_clk_i);
         r = bresp;
         if (bvalid === 1'b1) break;
         ah = awv && awr === 1'b1;
         wh = wv && wr_rdy === 1'b1;
         @(posedge core_clk_i);
         if (ah) awv <= 1'b0;
         if (wh) wv <= 1'b0;
      end
      @(posedge core_clk_i);
      bready <= 1'b0;
      cmp("bresp", (m < 0) ? tcpwm_pkg::RESP_SLVERR : tcpwm_pkg::RESP_OKAY, r);
      if (m >= 0) mreg[a] = d & m;
   endtask : bus_wr

   task automatic bus_rd(input int a, output logic [31:0] d, output logic [1:0] r);
      bit ah;
      @(posedge core_clk_i);
      araddr <= a[7:0];
      arv <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(negedge core_clk_i);
         d = rdata;
         r = rresp;
         if (rvalid === 1'b1) break;
         ah = arv && arr === 1'b1;
         @(posedge core_clk_i);
         if (ah) arv <= 1'b0;
      end
      @(posedge core_clk_i);
      rready <= 1'b0;
   endtask : bus_rd

   task automatic chk(input int a);
      logic [31:0] d;
      logic [1:0] r;
      int m;
      m = mask_of(a);
      bus_rd(a, d, r);
      cmp("rresp", (m < 0) ? tcpwm_pkg::RESP_SLVERR : tcpwm_pkg::RESP_OKAY, r);
      cmp("rdata", (m < 0) ? 0 : mreg[a], d);
   endtask : chk

   // Aligns on the first rise after enable, which is phase 0 of sub-cycle 0, and counts high clocks per sub-cycle.
   task automatic measure(input int ch, input int duty, input int div);
      int cnt[16];
      int s;
      foreach (cnt[i]) cnt[i] = 0;
      @(negedge core_clk_i);
      while (pin_o[ch] !== 1'b0) @(negedge core_clk_i);
      while (pin_o[ch] !== 1'b1) @(negedge core_clk_i);
      for (int k = 0; k < 4096 * div; k++) begin
         s = k / (256 * div);
         cnt[s] += (pin_o[ch] === 1'b1);
         @(negedge core_clk_i);
      end
      for (int i = 0; i < 16; i++) begin
         cmp("high_clocks", ((duty >> 4) + (i < (duty & 15))) * div, cnt[i]);
      end
   endtask : measure

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int duty;
      for (int a = 0; a <= 48; a += 4) mreg[a] = (a == 40) ? tcpwm_pkg::RST_PORT_DIR : 0;
      repeat (8) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      for (int a = 0; a <= 56; a += 4) if (a != 52) chk(a);
      bus_wr(252, 255);
      chk(252);
      $display("test reset_and_map done");
      for (int a = 0; a <= 48; a += 4) begin
         rnd = lfsr(rnd);
         bus_wr(a, {rnd, rnd});
         chk(a);
      end
      $display("test register_rw done");
      for (int ch = 0; ch < 3; ch++) bus_wr(ch * 12, 0);
      bus_wr(44, 7);
      bus_wr(40, 0);
      for (int p = 0; p < 2; p++) begin
         bus_wr(36, p);
         for (int ch = 0; ch < 3; ch++) begin
            rnd = lfsr(rnd);
            duty = (ch == 1) ? 'h10F : (ch == 2) ? 'hFE0 : ((16 + rnd % 200) << 4) | rnd[15:12];
            bus_wr(ch * 12 + 8, p ? 0 : ch);
            bus_wr(ch * 12 + 4, duty >> 4);
            bus_wr(ch * 12, ((duty & 15) << 4) | 1);
            measure(ch, duty, p ? 4 : ch + 1);
            bus_wr(ch * 12, 0);
         end
      end
      $display("test modulator done");
      for (int ch = 0; ch < 3; ch++) bus_wr(ch * 12, 1);
      repeat (20) @(posedge core_clk_i);
      clk_en_i <= 1'b0;
      repeat (6) @(posedge core_clk_i);
      clk_en_i <= 1'b1;
      bus_wr(44, 0);
      repeat (4) @(posedge core_clk_i);
      repeat (600) begin
         @(negedge core_clk_i);
         cmp("pin_o", 0, pin_o);
      end
      bus_wr(40, 7);
      bus_wr(48, 7);
      // The pull-high reaches the status bits through the pin driver and two synchroniser flops.
      repeat (4) @(posedge core_clk_i);
      bus_rd(52, d, r);
      cmp("pin_oe_n", 7, oe_n);
      cmp("pin_pull", 7, pull);
      cmp("status_pins", 7, d & 7);
      for (int ch = 0; ch < 3; ch++) bus_wr(ch * 12, 0);
      bus_wr(40, 0);
      bus_wr(44, 5);
      repeat (4) @(posedge core_clk_i);
      cmp("gpio_out", 5, pin_o);
      $display("test pin_sharing done");
      end_of_test();
   end
endmodule : tb_top
